/* logic/slb_blinker.v */
/*
 * status lamp driver: fast alternation, steady ready, blink code and
 * steady red fatal indication.
 * assumes start-up and error inputs come from logic on mclk; the
 * config switch is a pin and is synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
`include "slb_defs.vh"
module slb_blinker #(
  parameter [31:0] TICK_CYC = `SLB_TICK_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // device state
  input wire booting,
  input wire cfg_mode,
  input wire fatal,
  input wire err_valid,
  input wire [3:0] err_tens,
  input wire [3:0] err_ones,
  // config switch pin
  input wire cfg_switch,
  // outputs
  output reg [1:0] status_lamp,
  output reg update_mode,
  output reg [3:0] code_tens,
  output reg [3:0] code_ones,
  output reg code_held
);
  localparam [1:0] ST_GAP = 2'h0;
  localparam [1:0] ST_LONG = 2'h1;
  localparam [1:0] ST_SHORT = 2'h2;

  wire tick;
  reg sw_s1, sw_s2, sw_s3;
  reg sw_last;
  reg [7:0] hold_cnt;
  reg fast_ph;
  reg [7:0] fast_cnt;
  reg [1:0] state;
  reg [7:0] dur;
  reg half;
  reg [3:0] flashes;
  reg [1:0] next_lamp;
  wire sw_on;
  wire fast;
  wire [7:0] half_len;

  slb_tick #(.DIV(TICK_CYC)) u_tick (
    .mclk(mclk),
    .rst(rst),
    .tick(tick)
  );

  // switch change counted once stages two and three agree
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sw_s1 <= 1'b0;
      sw_s2 <= 1'b0;
      sw_s3 <= 1'b0;
      sw_last <= 1'b0;
    end else begin
      sw_s1 <= cfg_switch;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
      sw_last <= sw_on;
    end
  end
  // stages that disagree keep the last settled level
  assign sw_on = (sw_s2 == sw_s3) ? sw_s3 : sw_last;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_cnt <= 8'h0;
      update_mode <= 1'b0;
    end else begin
      if (!sw_on)
        hold_cnt <= 8'h0;
      else if (tick && hold_cnt != `SLB_HOLD_TICKS)
        hold_cnt <= hold_cnt + 8'h1;
      if (sw_on && hold_cnt == `SLB_HOLD_TICKS)
        update_mode <= 1'b1;
      else if (!cfg_mode && !sw_on)
        update_mode <= update_mode;
    end
  end

  // digits outside 1 to 9 are not accepted
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      code_held <= 1'b0;
      code_tens <= 4'h0;
      code_ones <= 4'h0;
    end else if (err_valid && !code_held && err_tens != 4'h0 &&
                 err_tens <= 4'h9 && err_ones != 4'h0 &&
                 err_ones <= 4'h9) begin
      code_held <= 1'b1;
      code_tens <= err_tens;
      code_ones <= err_ones;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fast_ph <= 1'b0;
      fast_cnt <= 8'h0;
    end else if (tick) begin
      if (fast_cnt + 8'h1 >= `SLB_FAST_TICKS) begin
        fast_cnt <= 8'h0;
        fast_ph <= ~fast_ph;
      end else begin
        fast_cnt <= fast_cnt + 8'h1;
      end
    end
  end

  // config and update modes share the start-up pattern
  assign fast = booting | cfg_mode | update_mode;
  assign half_len = (state == ST_LONG) ? `SLB_LONG_TICKS :
                    (state == ST_SHORT) ? `SLB_SHORT_TICKS :
                    `SLB_GAP_TICKS;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_GAP;
      dur <= 8'h0;
      half <= 1'b0;
      flashes <= 4'h0;
    end else if (!code_held || fast) begin
      state <= ST_GAP;
      dur <= 8'h0;
      half <= 1'b0;
      flashes <= 4'h0;
    end else if (tick) begin
      if (dur + 8'h1 < half_len) begin
        dur <= dur + 8'h1;
      end else begin
        dur <= 8'h0;
        case (state)
          ST_GAP: begin
            state <= ST_LONG;
            half <= 1'b0;
            flashes <= 4'h0;
          end
          ST_LONG: begin
            half <= ~half;
            if (half) begin
              if (flashes + 4'h1 == code_tens) begin
                state <= ST_SHORT;
                flashes <= 4'h0;
              end else begin
                flashes <= flashes + 4'h1;
              end
            end
          end
          ST_SHORT: begin
            half <= ~half;
            if (half) begin
              if (flashes + 4'h1 == code_ones) begin
                state <= ST_GAP;
                flashes <= 4'h0;
              end else begin
                flashes <= flashes + 4'h1;
              end
            end
          end
          default: begin
            state <= ST_GAP;
          end
        endcase
      end
    end
  end

  // fast patterns outrank error codes; fatal outranks ready while the switch is released
  always @* begin
    next_lamp = `SLB_LAMP_YEL;
    if (fast) begin
      next_lamp = fast_ph ? `SLB_LAMP_RED : `SLB_LAMP_YEL;
    end else if (code_held) begin
      if (state != ST_GAP && !half)
        next_lamp = `SLB_LAMP_RED;
      else
        next_lamp = `SLB_LAMP_YEL;
    end else if (fatal && !sw_on) begin
      next_lamp = `SLB_LAMP_RED;
    end else begin
      next_lamp = `SLB_LAMP_YEL;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst)
      status_lamp <= `SLB_LAMP_OFF;
    else
      status_lamp <= next_lamp;
  end
endmodule
`default_nettype wire

/* logic/slb_defs.vh */
/*
 * constants for the status lamp blinker: lamp colour codes, timebase
 * and flash durations in ticks of a 100 ms enable.
 * assumes a 50 MHz system clock and an includer that sets no macros
 * of the same names.
 */
`ifndef SLB_DEFS_VH
`define SLB_DEFS_VH
// 100 ms tick at 50 MHz
`define SLB_TICK_CYC 32'h004c4b40
`define SLB_FAST_TICKS 8'h01
`define SLB_SHORT_TICKS 8'h02
`define SLB_LONG_TICKS 8'h0a
`define SLB_GAP_TICKS 8'h1e
`define SLB_HOLD_TICKS 8'h1e
`define SLB_LAMP_OFF 2'h0
`define SLB_LAMP_RED 2'h1
`define SLB_LAMP_YEL 2'h2
`endif

/* logic/slb_tick.v */
/*
 * prescaler: one-cycle enable pulse every div cycles.
 * assumes a single clock and div of at least two.
 */
`timescale 1ns/1ns
`default_nettype none
`include "slb_defs.vh"
module slb_tick #(
  parameter [31:0] DIV = `SLB_TICK_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // enable out
  output reg tick
);
  reg [31:0] cnt;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else if (cnt == DIV - 32'h1) begin
      cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sim/slb_monitor.sv */
/* assertions on the blinker ports.
   assumes a tick of TICK_CYC cycles, 10 in the bench. */
`timescale 1ns/1ns
`default_nettype none
module slb_monitor #(
  parameter [31:0] TICK_CYC = 10
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // watched ports
  input wire booting,
  input wire cfg_mode,
  input wire fatal,
  input wire err_valid,
  input wire [3:0] err_tens,
  input wire [3:0] err_ones,
  input wire cfg_switch,
  input wire [1:0] status_lamp,
  input wire update_mode,
  input wire [3:0] code_tens,
  input wire [3:0] code_ones,
  input wire code_held
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire fast = booting | cfg_mode | update_mode;
  wire quiet = !fast && !code_held;
  wire ok = err_valid && err_tens > 4'h0 && err_tens < 4'ha &&
    err_ones > 4'h0 && err_ones < 4'ha;
  reg [9:0] run;
  reg [9:0] hold;
  reg [1:0] prev;
  // run is one short of the length of the stretch that ends
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run <= 10'h000;
      hold <= 10'h000;
      prev <= 2'h0;
    end else begin
      run <= (status_lamp == prev) ? run + 10'h001 : 10'h000;
      hold <= cfg_switch ? hold + 10'h001 : 10'h000;
      prev <= status_lamp;
    end
  end
  sequence gap_s;
    (status_lamp == 2'h2) throughout ##279 1'b1;
  endsequence
  latch_code_a: assert property (
    ok && !code_held |=> code_held && code_tens == $past(err_tens) &&
    code_ones == $past(err_ones)) else $error("code not latched");
  code_hold_a: assert property (
    code_held |=> code_held && $stable(code_tens) && $stable(code_ones))
    else $error("code changed");
  ready_yel_a: assert property (
    quiet && !fatal ##1 quiet && !fatal |-> status_lamp == 2'h2)
    else $error("not steady yellow");
  fast_alt_a: assert property (
    fast [*8] ##1 fast [*4] |-> run < 12 && status_lamp != 2'h0)
    else $error("no fast alternation");
  fatal_red_a: assert property (
    (fatal && !cfg_switch && quiet) [*5] |-> status_lamp == 2'h1)
    else $error("no steady red");
  upd_hold_a: assert property (
    $rose(update_mode) |-> hold >= 10'h118 && hold <= 10'h140)
    else $error("update mode at wrong hold time");
  flash_len_a: assert property (
    code_held && !fast && prev == 2'h1 && status_lamp != 2'h1 |->
    run == 10 * TICK_CYC - 1 || run == 2 * TICK_CYC - 1)
    else $error("bad red flash length");
  gap_first_a: assert property (
    $rose(code_held) && !fast |-> ##1 gap_s ##[1:35] status_lamp == 2'h1)
    else $error("bad yellow gap");
endmodule
bind slb_blinker slb_monitor #(.TICK_CYC(TICK_CYC)) mon (.mclk, .rst,
  .booting, .cfg_mode, .fatal, .err_valid, .err_tens, .err_ones,
  .cfg_switch, .status_lamp, .update_mode, .code_tens, .code_ones,
  .code_held);
`default_nettype wire

/* sim/slb_lamp_obs.sv */
/* lamp model: counts the red flashes it shows.
   assumes the lamp colour codes of the blinker. */
`timescale 1ns/1ns
`default_nettype none
module slb_lamp_obs (
  // clock and reset
  input wire mclk,
  input wire rst,
  // lamp and count
  input wire [1:0] status_lamp,
  output reg [7:0] reds
);
  reg [1:0] last;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reds <= 8'h00;
      last <= 2'h0;
    end else begin
      last <= status_lamp;
      if (last == 2'h1 && status_lamp == 2'h2)
        reds <= reds + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* sim/slb_blinker_tb.sv */
/* bench for the lamp blinker.
   assumes TICK_CYC of 10, so a tick is 10 cycles. */
`timescale 1ns/1ns
`default_nettype none
module slb_blinker_tb;
  reg mclk = 0, rst = 1, booting = 1, cfg_mode = 0, fatal = 0;
  reg err_valid = 0, cfg_switch = 0;
  reg [3:0] err_tens = 0, err_ones = 0;
  reg [1:0] a;
  wire [1:0] status_lamp;
  wire update_mode, code_held;
  wire [3:0] code_tens, code_ones;
  wire [7:0] reds;
  integer num_errors = 0, cmp_count = 0, cyc = 0;
  slb_blinker #(.TICK_CYC(10)) dut (.mclk, .rst, .booting, .cfg_mode,
    .fatal, .err_valid, .err_tens, .err_ones, .cfg_switch, .status_lamp,
    .update_mode, .code_tens, .code_ones, .code_held);
  slb_lamp_obs lamp (.mclk, .rst, .status_lamp, .reds);
  always #10 mclk = ~mclk;
  task tally_and_finish;
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  task w(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input ok);
    cmp_count = cmp_count + 1;
    if (ok !== 1'b1) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t lamp blinker mismatch", $time);
    end
  endtask
  task t_fast;
    w(15);
    a = status_lamp;
    w(10);
    chk(status_lamp !== a && status_lamp !== 2'h0);
  endtask
  task t_fatal;
    fatal = 1;
    w(5);
    chk(status_lamp === 2'h1);
    cfg_switch = 1;
    w(6);
    chk(status_lamp === 2'h2);
    w(320);
    chk(update_mode === 1'b1);
    t_fast;
  endtask
  task t_code;
    err_valid = 1;
    err_ones = 5;
    w(1);
    chk(code_held === 1'b0);
    err_tens = 4'ha;
    w(1);
    chk(code_held === 1'b0);
    err_tens = 4'h3;
    err_ones = 4'hb;
    w(1);
    chk(code_held === 1'b0);
    err_ones = 4'h2;
    w(1);
    chk(code_held === 1'b1);
    chk(code_tens === 4'h3 && code_ones === 4'h2);
    err_tens = 4'h9;
    w(1200);
    chk(reds === 8'h05);
    chk(code_tens === 4'h3 && code_ones === 4'h2);
  endtask
  task t_ready;
    booting = 0;
    w(3);
    chk(status_lamp === 2'h2);
  endtask
  initial begin
    w(12);
    rst = 0;
    t_fast;
    t_ready;
    cfg_mode = 1;
    t_fast;
    cfg_mode = 0;
    t_fatal;
    cfg_switch = 0;
    fatal = 0;
    rst = 1;
    w(12);
    rst = 0;
    w(3);
    t_code;
    tally_and_finish;
  end
endmodule
`default_nettype wire
